// File: rmob_bank.v
`timescale 1ns/1ps
`include "rmob_map.vh"

module rmob_bank #(
    parameter NUM_PERIPH = 19
) (
    input wire pclk,
    input wire presetn,
    input wire pce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [NUM_PERIPH-1:0] periph_out,
    input wire [`RMOB_NUM_PINS-1:0] port_out,
    output reg [`RMOB_NUM_PINS-1:0] remap_pin_out,
    output reg [`RMOB_NUM_PINS-1:0] remap_pin_periph
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Pin order: 6,7,8,9,10,11,13,14,15 at index 0..8
    function [2:0] reg_of_addr;
        input [11:0] a;
        begin
            case (a)
                `RMOB_OFS_PINS_7_6: reg_of_addr = 3'h0;
                `RMOB_OFS_PINS_9_8: reg_of_addr = 3'h1;
                `RMOB_OFS_PINS_11_10: reg_of_addr = 3'h2;
                `RMOB_OFS_PIN_13: reg_of_addr = 3'h3;
                `RMOB_OFS_PINS_15_14: reg_of_addr = 3'h4;
                default: reg_of_addr = `RMOB_REG_NONE;
            endcase
        end
    endfunction

    function [2:0] reg_of_pin;
        input [3:0] i;
        begin
            case (i)
                4'h0: reg_of_pin = 3'h0;
                4'h1: reg_of_pin = 3'h0;
                4'h2: reg_of_pin = 3'h1;
                4'h3: reg_of_pin = 3'h1;
                4'h4: reg_of_pin = 3'h2;
                4'h5: reg_of_pin = 3'h2;
                4'h6: reg_of_pin = 3'h3;
                4'h7: reg_of_pin = 3'h4;
                4'h8: reg_of_pin = 3'h4;
                default: reg_of_pin = `RMOB_REG_NONE;
            endcase
        end
    endfunction

    // High half holds the odd pin, and pin 13 alone
    function pin_is_high;
        input [3:0] i;
        begin
            case (i)
                4'h1: pin_is_high = 1'b1;
                4'h3: pin_is_high = 1'b1;
                4'h5: pin_is_high = 1'b1;
                4'h6: pin_is_high = 1'b1;
                4'h8: pin_is_high = 1'b1;
                default: pin_is_high = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Selector storage
    // ----------------------------------------------------------------
    reg [`RMOB_SEL_W-1:0] sel_ff [0:`RMOB_NUM_PINS-1];
    wire [2:0] hit_reg = reg_of_addr(paddr);
    wire mapped = (hit_reg != `RMOB_REG_NONE);
    wire setup = psel & ~penable;
    wire wr_take = psel & penable & pready & pwrite & mapped;
    wire [`RMOB_SEL_W-1:0] hi_field = pwdata[`RMOB_HI_MSB:`RMOB_HI_LSB];
    wire [`RMOB_SEL_W-1:0] lo_field = pwdata[`RMOB_LO_MSB:`RMOB_LO_LSB];
    wire [`RMOB_NUM_PINS-1:0] pin_in_reg;
    wire [`RMOB_NUM_PINS-1:0] pin_high;
    wire [`RMOB_NUM_PINS-1:0] pin_we;
    reg [31:0] nxt_rdata;
    integer k;

    // Each pin knows its register and half once, so its write enable and stored field cannot disagree
    genvar d;
    generate
        for (d = 0; d < `RMOB_NUM_PINS; d = d + 1) begin : g_dec
            localparam [3:0] PIN_IDX = d;

            assign pin_in_reg[d] = (reg_of_pin(PIN_IDX) == hit_reg);
            assign pin_high[d] = pin_is_high(PIN_IDX);

            // A low lane strobe leaves its field untouched
            assign pin_we[d] = wr_take & pin_in_reg[d] & (pin_high[d] ? pstrb[1] : pstrb[0]);
        end
    endgenerate

    // Unwritten bit positions never reach storage, so 15:13, 7:5 and the pin 13 low byte stay zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (k = 0; k < `RMOB_NUM_PINS; k = k + 1) begin
                sel_ff[k] <= `RMOB_SEL_RESET;
            end
        end else if (pce) begin
            for (k = 0; k < `RMOB_NUM_PINS; k = k + 1) begin
                if (pin_we[k]) begin
                    if (pin_high[k]) begin
                        sel_ff[k] <= hi_field;
                    end else begin
                        sel_ff[k] <= lo_field;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Register views
    // ----------------------------------------------------------------
    // Each register is rebuilt as a 16-bit view with its unimplemented bits tied low
    wire [15:0] view_pins_7_6 = {3'h0, sel_ff[1], 3'h0, sel_ff[0]};
    wire [15:0] view_pins_9_8 = {3'h0, sel_ff[3], 3'h0, sel_ff[2]};
    wire [15:0] view_pins_11_10 = {3'h0, sel_ff[5], 3'h0, sel_ff[4]};
    wire [15:0] view_pin_13 = {3'h0, sel_ff[6], 8'h00};
    wire [15:0] view_pins_15_14 = {3'h0, sel_ff[8], 3'h0, sel_ff[7]};

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Bits 31:16 have no storage at all and always read zero
    always @* begin
        nxt_rdata = 32'h00000000;
        case (hit_reg)
            3'h0: begin
                nxt_rdata[15:0] = view_pins_7_6;
            end
            3'h1: begin
                nxt_rdata[15:0] = view_pins_9_8;
            end
            3'h2: begin
                nxt_rdata[15:0] = view_pins_11_10;
            end
            3'h3: begin
                nxt_rdata[15:0] = view_pin_13;
            end
            3'h4: begin
                nxt_rdata[15:0] = view_pins_15_14;
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait-free access: the answer is prepared in the setup cycle,
    // so pready is high at the first access edge.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (pce) begin
            pready <= setup;
        end
    end

    // Unmapped offsets answer with an error rather than aliasing onto a selector
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (pce) begin
            pslverr <= setup & ~mapped;
        end
    end

    // Read data stands only with pready; writes and errors read back zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (pce) begin
            if (setup && !pwrite && mapped) begin
                prdata <= nxt_rdata;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin routing
    // ----------------------------------------------------------------
    // Registered so the pins never glitch while a selector changes
    genvar g;
    generate
        for (g = 0; g < `RMOB_NUM_PINS; g = g + 1) begin : g_pin
            // Numbers past the last peripheral fall back to port data instead of reading off the end
            wire use_periph = (sel_ff[g] != `RMOB_SEL_NONE) && (sel_ff[g] < NUM_PERIPH);
            wire nxt_pin_out = use_periph ? periph_out[sel_ff[g]] : port_out[g];

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    remap_pin_periph[g] <= 1'b0;
                end else if (pce) begin
                    remap_pin_periph[g] <= use_periph;
                end
            end

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    remap_pin_out[g] <= 1'b0;
                end else if (pce) begin
                    remap_pin_out[g] <= nxt_pin_out;
                end
            end
        end
    endgenerate

endmodule // rmob_bank

// File: rmob_bank_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bus and pin checks
// ----------------------------------------
module rmob_bank_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [8:0] port_out,
    input wire [8:0] remap_pin_out,
    input wire [8:0] remap_pin_periph
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence wr6_s;
        psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[4:0] == 5'h03;
    endsequence
    ready_next_a: assert property (setup_s |=> pready) else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    top_zero_a: assert property (pready |-> prdata[15:13] == 3'h0) else $error("top bits set");
    mid_zero_a: assert property (pready && paddr != 12'h00c |-> prdata[7:5] == 3'h0)
        else $error("mid bits set");
    pin13_low_a: assert property (pready && paddr == 12'h00c |-> prdata[7:0] == 8'h00)
        else $error("low byte set");
    route_sel_a: assert property (wr6_s |-> ##2 remap_pin_periph[0]) else $error("pin six not routed");
    port_pass_a: assert property (!remap_pin_periph[4] |-> remap_pin_out[4] == $past(port_out[4]))
        else $error("port data lost");
    err_only_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("stray error");
endmodule // rmob_bank_sva
bind rmob_bank rmob_bank_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_out(port_out), .remap_pin_out(remap_pin_out), .remap_pin_periph(remap_pin_periph));

// File: rmob_bank_test.sv
`timescale 1ns/1ps
// ----------------------------------------
// Register and pin tests
// ----------------------------------------
module rmob_bank_test;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [18:0] periph_out = 19'h0;
    logic [8:0] port_out = 9'h0, remap_pin_out, remap_pin_periph;
    int n_errors = 0, checks = 0;
    always #20 pclk = ~pclk;
    rmob_bank dut_u (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_out(periph_out), .port_out(port_out), .remap_pin_out(remap_pin_out),
        .remap_pin_periph(remap_pin_periph));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Taken at the rising edge, the same edge at which the slave stores a write
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task test_done;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task t_regs;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("reset", rd, 32'h0);
            apb(1'b1, 12'(i * 4), 32'hffffffff);
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("mask", rd, (i == 3) ? 32'h00001f00 : 32'h00001f1f);
            apb(1'b1, 12'(i * 4), 32'h0);
        end
    endtask
    task t_route;
        periph_out <= 19'h0003a;
        apb(1'b1, 12'h010, 32'h00000504);
        apb(1'b1, 12'h000, 32'h00000103);
        apb(1'b0, 12'h000, 32'h0);
        chk("pins76", rd, 32'h00000103);
        repeat (2) @(negedge pclk);
        chk("periph", {23'h0, remap_pin_periph}, 32'h00000183);
        chk("out", {23'h0, remap_pin_out}, 32'h00000183);
        periph_out <= 19'h0;
        repeat (2) @(negedge pclk);
        chk("out low", {23'h0, remap_pin_out}, 32'h0);
    endtask
    task t_none;
        // All peripherals high, so only a pin left on port data can read low
        periph_out <= 19'h7ffff;
        port_out <= 9'h010;
        apb(1'b1, 12'h008, 32'h00001f00);
        repeat (2) @(negedge pclk);
        chk("none", {28'h0, remap_pin_out[5:4], remap_pin_periph[5:4]}, 32'h00000004);
    endtask
    task t_bad;
        apb(1'b1, 12'h014, 32'hffffffff);
        chk("werr", {31'h0, er}, 32'h1);
        apb(1'b0, 12'h002, 32'h0);
        chk("rerr", {31'h0, er}, 32'h1);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_route;
        t_none;
        t_bad;
        test_done;
    end
    initial begin
        #100000;
        n_errors++;
        test_done;
    end
endmodule // rmob_bank_test

// File: rmob_map.vh
`ifndef RMOB_MAP_VH
`define RMOB_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RMOB_OFS_PINS_7_6 12'h000
`define RMOB_OFS_PINS_9_8 12'h004
`define RMOB_OFS_PINS_11_10 12'h008
`define RMOB_OFS_PIN_13 12'h00c
`define RMOB_OFS_PINS_15_14 12'h010

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define RMOB_SEL_W 5
`define RMOB_HI_LSB 8
`define RMOB_HI_MSB 12
`define RMOB_LO_LSB 0
`define RMOB_LO_MSB 4
`define RMOB_SEL_RESET 5'h00
`define RMOB_SEL_NONE 5'h00
`define RMOB_NUM_REGS 5
`define RMOB_NUM_PINS 9
`define RMOB_REG_NONE 3'h7

`endif
